// [ssc_ctrl.sv]
/*
  ssc_ctrl: sleep, wake and serial output control of a small converter.
  Assumes the host drives the serial clock and chip select synchronously
  to clk_i; the modulator supplies a result word, taken at a conversion end unless a word is mid-shift.
*/
`timescale 1ns/100ps
`default_nettype none
module ssc_ctrl
  import ssc_pkg::*;
#(
  parameter bit INT_OSC = 1'b0,
  parameter logic [TMR_W-1:0] SLEEP_LIMIT = TMR_W'(SLEEP_CYC),
  parameter logic [TMR_W-1:0] WAKE_LIMIT = TMR_W'(WAKE_CYC)
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic arst_n_i,
  // host serial link
  input wire logic serial_clk_i,
  input wire logic cs_n_i,
  output logic serial_data_out_o,
  output logic serial_data_out_oe_n_o,
  // internal oscillator tick (internal variant)
  input wire logic osc_tick_i,
  // modulator result, two's complement with flags
  input wire logic [WORD_W-1:0] result_i,
  // status toward the analog core
  output logic sleep_o,
  output logic filter_rst_o,
  output logic conv_done_o,
  output logic settled_o
);
  ssc_pwr_type pwr_reg;
  ssc_pwr_type pwr_next;
  logic sleep_done;
  logic wake_done;
  logic sck_rise;
  logic sck_fall;
  logic conv_tick;
  logic [DIV_W-1:0] div_reg;
  logic [DIV_W-1:0] div_next;
  logic [SET_W-1:0] set_reg;
  logic [SET_W-1:0] set_next;
  logic [WORD_W-1:0] sh_reg;
  logic [WORD_W-1:0] sh_next;
  logic [BIT_W-1:0] bit_reg;
  logic [BIT_W-1:0] bit_next;
  logic rdy_reg;
  logic rdy_next;
  logic sdo_reg;
  logic sdo_next;
  logic done_reg;
  logic done_next;

  // time the high clock for sleep and the low clock for wake
  ssc_hold_timer #(.LIMIT(SLEEP_LIMIT)) u_sleep_tmr (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .level_i(serial_clk_i),
    .done_o(sleep_done)
  );

  ssc_hold_timer #(.LIMIT(WAKE_LIMIT)) u_wake_tmr (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .level_i(~serial_clk_i),
    .done_o(wake_done)
  );

  ssc_edge_det u_sck_edge (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .level_i(serial_clk_i),
    .rise_o(sck_rise),
    .fall_o(sck_fall)
  );

  // power state machine
  always_comb begin
    pwr_next = pwr_reg;
    unique case (pwr_reg)
      SSC_RUN: begin
        if (sleep_done) begin
          pwr_next = SSC_SLEEP;
        end
      end
      SSC_SLEEP: begin
        if (wake_done) begin
          pwr_next = SSC_WAKING;
        end
      end
      SSC_WAKING: begin
        pwr_next = SSC_RUN;
      end
      default: begin
        pwr_next = SSC_RUN;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pwr_reg <= SSC_RUN;
    end else begin
      pwr_reg <= pwr_next;
    end
  end

  assign sleep_o = (pwr_reg == SSC_SLEEP);
  assign filter_rst_o = (pwr_reg != SSC_RUN);

  // conversion clock source per variant
  assign conv_tick = INT_OSC ? osc_tick_i : sck_rise;

  // conversion divider and settling count
  always_comb begin
    div_next = div_reg;
    set_next = set_reg;
    done_next = 1'b0;
    if (pwr_reg != SSC_RUN) begin
      div_next = '0;
      set_next = '0;
    end else if (conv_tick) begin
      if (div_reg == DIV_W'(CONV_DIV - 1)) begin
        div_next = '0;
        done_next = 1'b1;
        if (set_reg != SET_W'(UNSETTLED_N)) begin
          set_next = set_reg + 1'b1;
        end
      end else begin
        div_next = div_reg + 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      div_reg <= '0;
      set_reg <= '0;
      done_reg <= 1'b0;
    end else begin
      div_reg <= div_next;
      set_reg <= set_next;
      done_reg <= done_next;
    end
  end

  assign conv_done_o = done_reg;
  assign settled_o = (set_reg == SET_W'(UNSETTLED_N));

  // result shifter: load on conversion end, shift on falling clock
  always_comb begin
    sh_next = sh_reg;
    bit_next = bit_reg;
    rdy_next = rdy_reg;
    sdo_next = sdo_reg;
    if (pwr_reg != SSC_RUN) begin
      rdy_next = 1'b0;
      bit_next = '0;
      sdo_next = 1'b1;
    end else if (done_next && (!rdy_reg || bit_reg == '0)) begin
      sh_next = result_i;
      rdy_next = 1'b1;
      bit_next = '0;
      sdo_next = 1'b0; // low signals a word ready
    end else if (rdy_reg && sck_fall) begin
      sdo_next = sh_reg[WORD_W-1];
      sh_next = {sh_reg[WORD_W-2:0], 1'b0};
      if (bit_reg == LAST_BIT) begin
        bit_next = '0;
        rdy_next = 1'b0;
      end else begin
        bit_next = bit_reg + 1'b1;
      end
    end else if (!rdy_reg && sck_fall) begin
      sdo_next = 1'b1; // last bit stands until the next fall
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sh_reg <= '0;
      bit_reg <= '0;
      rdy_reg <= 1'b0;
      sdo_reg <= 1'b1;
    end else begin
      sh_reg <= sh_next;
      bit_reg <= bit_next;
      rdy_reg <= rdy_next;
      sdo_reg <= sdo_next;
    end
  end

  // driver enabled by chip select only, regardless of sleep
  assign serial_data_out_o = sdo_reg;
  assign serial_data_out_oe_n_o = cs_n_i;

  // power mode checks: entry, hold and wake
  sleep_entry_a: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    (pwr_reg == SSC_RUN && sleep_done) |=> sleep_o)
    else $error("sleep not entered after long high clock");

  no_early_a: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    $rose(sleep_o) |-> $past(serial_clk_i))
    else $error("sleep entered without high clock");

  sleep_hold_a: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    (sleep_o && !wake_done) |=> sleep_o)
    else $error("sleep left before the wake time");

  sequence wake_seq;
    sleep_o ##1 (pwr_reg == SSC_WAKING);
  endsequence

  wake_reset_a: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    wake_seq |-> filter_rst_o ##1 (pwr_reg == SSC_RUN && div_reg == '0))
    else $error("wake did not reset and resume");

  // the wake step needs the clock sampled low two cycles before
  wake_low_a: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    (pwr_reg == SSC_WAKING) |-> !$past(serial_clk_i, 2))
    else $error("woke while clock high");

  // output driver follows chip select, also in sleep
  drv_en_a: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    cs_n_i |-> serial_data_out_oe_n_o)
    else $error("driver enabled while deselected");

  drv_sleep_a: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    (sleep_o && !cs_n_i) |-> !serial_data_out_oe_n_o)
    else $error("driver switched off by sleep");

  // filter reset: line idles high, no results, settling restarts
  idle_sleep_a: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    filter_rst_o |=> serial_data_out_o)
    else $error("data line not idle during reset");

  no_conv_a: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    filter_rst_o |=> !conv_done_o)
    else $error("conversion finished outside run mode");

  settle_a: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    (filter_rst_o ##1 !filter_rst_o) |-> !settled_o)
    else $error("settled flag set right after reset");

  settle_hold_a: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    (settled_o && !filter_rst_o) |=> settled_o)
    else $error("settled flag dropped while running");

  // conversion pacing per variant
  conv_rate_a: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    conv_done_o |-> $past(div_reg) == DIV_W'(CONV_DIV - 1))
    else $error("conversion not at divider end");

  conv_pulse_a: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    conv_done_o |=> !conv_done_o)
    else $error("conversion strobe longer than one cycle");

  ext_tick_a: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    (!INT_OSC && pwr_reg == SSC_RUN && !sck_rise) |=> $stable(div_reg))
    else $error("divider moved without a serial clock rise");

  osc_tick_a: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    (INT_OSC && pwr_reg == SSC_RUN && !osc_tick_i) |=> $stable(div_reg))
    else $error("divider moved without an oscillator tick");

  // serial word: ready low on load, idle level held between falls
  sequence word_load_seq;
    !rdy_reg ##1 rdy_reg;
  endsequence

  word_ready_a: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    word_load_seq |-> !serial_data_out_o)
    else $error("word ready not shown low");

  sequence idle_seq;
    (pwr_reg == SSC_RUN) && !rdy_reg && !sck_fall && !done_next;
  endsequence

  last_hold_a: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    idle_seq |=> $stable(serial_data_out_o))
    else $error("data line changed without a clock fall");

  reset_run_a: assert property (
    @(posedge clk_i)
    $rose(arst_n_i) |-> !sleep_o)
    else $error("not in run mode after reset");
endmodule : ssc_ctrl
`default_nettype wire

// [ssc_pkg.sv]
/*
  ssc_pkg: constants shared by the sleep, wake and serial output control.
  Assumes a single 250 MHz system clock; serial clock sampled synchronously.
*/
package ssc_pkg;
  // system clock
  localparam int unsigned CLK_MHZ = 250;
  // sleep entry window, times in microseconds
  localparam int unsigned SLEEP_MIN_US = 200;
  localparam int unsigned SLEEP_MAX_US = 2000;
  localparam int unsigned WAKE_MIN_US = 10;
  // threshold placed between the two sleep figures (half the longest time)
  localparam int unsigned SLEEP_THR_US = 1000;
  localparam int unsigned SLEEP_CYC = SLEEP_THR_US * CLK_MHZ;
  localparam int unsigned WAKE_CYC = WAKE_MIN_US * CLK_MHZ;
  localparam int unsigned TMR_W = 20;
  // conversion clock edges per result
  localparam int unsigned CONV_DIV = 612;
  localparam int unsigned DIV_W = 10;
  // conversions after a filter reset up to the first settled result
  localparam int unsigned UNSETTLED_N = 3;
  localparam int unsigned SET_W = 2;
  // output word
  localparam int unsigned WORD_W = 24;
  localparam int unsigned BIT_W = 5;
  localparam logic [BIT_W-1:0] LAST_BIT = 5'h17;
  // power state, gray along run->sleep->waking
  typedef enum logic [1:0] {
    SSC_RUN = 2'h0,
    SSC_SLEEP = 2'h1,
    SSC_WAKING = 2'h3
  } ssc_pwr_type;
endpackage : ssc_pkg

// [ssc_hold_timer.sv]
/*
  ssc_hold_timer: counts consecutive cycles a level is held, saturating.
  Assumes level_i is synchronous to clk_i.
*/
`timescale 1ns/100ps
`default_nettype none
module ssc_hold_timer
  import ssc_pkg::*;
#(
  parameter logic [TMR_W-1:0] LIMIT = 20'h00001
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic arst_n_i,
  // level to time
  input wire logic level_i,
  // reached the limit
  output logic done_o
);
  logic [TMR_W-1:0] cnt_reg;
  logic [TMR_W-1:0] cnt_next;

  // restart on a low level, saturate at limit
  always_comb begin
    if (!level_i) begin
      cnt_next = '0;
    end else if (cnt_reg < LIMIT) begin
      cnt_next = cnt_reg + 1'b1;
    end else begin
      cnt_next = cnt_reg;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  assign done_o = (cnt_reg >= LIMIT);
endmodule : ssc_hold_timer
`default_nettype wire

// [ssc_edge_det.sv]
/*
  ssc_edge_det: registers a level and flags its rising and falling edges.
  Assumes the input is synchronous to clk_i.
*/
`timescale 1ns/100ps
`default_nettype none
module ssc_edge_det (
  // clock and reset
  input wire logic clk_i,
  input wire logic arst_n_i,
  // level in
  input wire logic level_i,
  // edges out
  output logic rise_o,
  output logic fall_o
);
  logic prev_reg;
  logic prev_next;

  // remember last level
  always_comb begin
    prev_next = level_i;
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      prev_reg <= 1'b0;
    end else begin
      prev_reg <= prev_next;
    end
  end

  assign rise_o = level_i & ~prev_reg;
  assign fall_o = ~level_i & prev_reg;
endmodule : ssc_edge_det
`default_nettype wire

// [ssc_host_model.sv]
/*
  ssc_host_model: host side driving serial clock and chip select.
  Assumes clk_i is the bench clock; lines move 1 ns after its rise.
*/
`timescale 1ns/100ps
`default_nettype none
module ssc_host_model (
  // bench clock
  input wire logic clk_i,
  // host serial link
  output logic serial_clk_o,
  output logic cs_n_o
);
  int rises = 0;

  // idle: clock low, chip deselected
  initial begin
    serial_clk_o = 1'b0;
    cs_n_o = 1'b1;
  end

  // hold a clock level for n cycles, counting rising edges
  task automatic set(input logic lvl, input int n);
    @(posedge clk_i);
    #1;
    if (lvl && !serial_clk_o) rises++;
    serial_clk_o = lvl;
    repeat (n - 1) @(posedge clk_i);
    #1;
  endtask : set

  // full periods, four cycles high then four low
  task automatic periods(input int n);
    repeat (n) begin
      set(1'b1, 4);
      set(1'b0, 4);
    end
  endtask : periods

  // low level that brings the converter out of sleep
  task automatic wake(input int n);
    set(1'b0, n);
  endtask : wake

  // chip select level
  task automatic select(input logic lvl);
    @(posedge clk_i);
    #1;
    cs_n_o = lvl;
    #1;
  endtask : select
endmodule : ssc_host_model
`default_nettype wire

// [ssc_ctrl_tb.sv]
/*
  ssc_ctrl_tb: self-checking bench for the sleep, wake and output control.
  Assumes short sleep and wake limits on the external clock variant;
  a second instance with default limits covers the oscillator variant.
*/
`timescale 1ns/100ps
`default_nettype none
module ssc_ctrl_tb;
  import ssc_pkg::*;
  localparam logic [TMR_W-1:0] SLP = 20'h00032;
  localparam logic [TMR_W-1:0] WAK = 20'h0000a;
  localparam logic [WORD_W-1:0] WORD = 24'h5a3c96;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic serial_clk, cs_n, serial_data_out, oe_n, sleep, frst, done, settled;
  logic [WORD_W-1:0] word = WORD;
  logic osc_tick = 1'b0;
  logic osc_sdo, osc_done;
  int errors = 0;
  int compares = 0;
  int dones = 0;
  int osc_dones = 0;
  int rise_at_done = 0;

  // 250 MHz clock
  always #2 clk = ~clk;

  ssc_host_model u_ssc_host_model (
    .clk_i(clk), .serial_clk_o(serial_clk), .cs_n_o(cs_n));

  ssc_ctrl #(.INT_OSC(1'b0), .SLEEP_LIMIT(SLP), .WAKE_LIMIT(WAK)) u_ssc_ctrl (
    .clk_i(clk), .arst_n_i(arst_n), .serial_clk_i(serial_clk),
    .cs_n_i(cs_n), .serial_data_out_o(serial_data_out),
    .serial_data_out_oe_n_o(oe_n), .osc_tick_i(osc_tick), .result_i(word),
    .sleep_o(sleep), .filter_rst_o(frst), .conv_done_o(done),
    .settled_o(settled));

  // internal oscillator variant, paced by osc_tick only
  ssc_ctrl #(.INT_OSC(1'b1)) u_ssc_ctrl_osc (
    .clk_i(clk), .arst_n_i(arst_n), .serial_clk_i(serial_clk),
    .cs_n_i(cs_n), .serial_data_out_o(osc_sdo),
    .serial_data_out_oe_n_o(), .osc_tick_i(osc_tick), .result_i(word),
    .sleep_o(), .filter_rst_o(), .conv_done_o(osc_done), .settled_o());

  // count completions, note the edge count at the first one
  always @(posedge clk) begin
    if (done === 1'b1) begin
      if (dones == 0) rise_at_done = u_ssc_host_model.rises;
      dones = dones + 1;
    end
    if (osc_done === 1'b1) osc_dones = osc_dones + 1;
  end

  task automatic chk_bit(input string name, input logic exp, input logic got);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("Error %s expected %b seen %b", name, exp, got);
    end
  endtask : chk_bit

  task automatic chk_num(input string name, input int exp, input int got);
    compares++;
    if (got != exp) begin
      errors++;
      $display("Error %s expected %0d seen %0d", name, exp, got);
    end
  endtask : chk_num

  task automatic test_done();
    if (errors == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : test_done

  // after reset: running, driver follows chip select
  task automatic t_reset();
    chk_bit("sleep", 1'b0, sleep);
    chk_bit("oe_n", 1'b1, oe_n);
    u_ssc_host_model.select(1'b0);
    chk_bit("oe_n", 1'b0, oe_n);
  endtask : t_reset

  // one conversion per 612 rises, word shifted out msb first
  task automatic t_word();
    u_ssc_host_model.periods(611);
    u_ssc_host_model.set(1'b1, 8);
    chk_num("rises", CONV_DIV, rise_at_done);
    chk_bit("ready", 1'b0, serial_data_out);
    for (int i = WORD_W - 1; i >= 0; i--) begin
      u_ssc_host_model.set(1'b0, 4);
      chk_bit("data", WORD[i], serial_data_out);
      u_ssc_host_model.set(1'b1, 4);
    end
    u_ssc_host_model.set(1'b0, 4);
    chk_bit("idle", 1'b1, serial_data_out);
  endtask : t_word

  // clock held high: sleep after the limit, driver kept on
  task automatic t_sleep();
    u_ssc_host_model.set(1'b1, 45);
    chk_bit("sleep", 1'b0, sleep);
    u_ssc_host_model.set(1'b1, 15);
    chk_bit("sleep", 1'b1, sleep);
    chk_bit("filter_rst", 1'b1, frst);
    chk_bit("oe_n", 1'b0, oe_n);
    u_ssc_host_model.select(1'b1);
    chk_bit("oe_n", 1'b1, oe_n);
    u_ssc_host_model.select(1'b0);
  endtask : t_sleep

  // clock held low: wake, reset, two unsettled results, settled at the third
  task automatic t_wake();
    int base;
    u_ssc_host_model.wake(6);
    chk_bit("sleep", 1'b1, sleep);
    u_ssc_host_model.wake(16);
    chk_bit("sleep", 1'b0, sleep);
    chk_bit("filter_rst", 1'b0, frst);
    chk_bit("idle", 1'b1, serial_data_out);
    chk_bit("settled", 1'b0, settled);
    base = dones;
    u_ssc_host_model.periods(2 * CONV_DIV);
    chk_num("dones", 2, dones - base);
    chk_bit("settled", 1'b0, settled);
    u_ssc_host_model.periods(CONV_DIV);
    chk_num("dones", 3, dones - base);
    chk_bit("settled", 1'b1, settled);
  endtask : t_wake

  // internal variant: only oscillator ticks pace conversions
  task automatic t_osc();
    int base;
    base = dones;
    chk_num("osc_dones", 0, osc_dones);
    repeat (CONV_DIV) begin
      @(posedge clk);
      #1;
      osc_tick = 1'b1;
      @(posedge clk);
      #1;
      osc_tick = 1'b0;
    end
    repeat (4) @(posedge clk);
    #1;
    chk_num("osc_dones", 1, osc_dones);
    chk_bit("osc_ready", 1'b0, osc_sdo);
    chk_num("dones", 0, dones - base);
  endtask : t_osc

  // main sequence
  initial begin
    repeat (12) @(posedge clk);
    #1;
    arst_n = 1'b1;
    t_reset();
    t_word();
    t_sleep();
    t_wake();
    t_osc();
    test_done();
  end

  // watchdog, about twice the expected run
  initial begin
    #200000;
    errors++;
    test_done();
  end
endmodule : ssc_ctrl_tb
`default_nettype wire
